/* File: core/rwg_pkg.sv */
// package with register map, fields and timing constants for the ringing generator
package rwg_pkg;
  // direct register byte offsets, index times four gives the bus byte address
  localparam logic [7:0] REG_DC_OFFSET_LO = 8'h13;
  localparam logic [7:0] REG_DC_OFFSET_HI = 8'h14;
  localparam logic [7:0] REG_CONTROL = 8'h22;
  localparam logic [7:0] REG_ON_A = 8'h30;
  localparam logic [7:0] REG_ON_B = 8'h31;
  localparam logic [7:0] REG_OFF_A = 8'h32;
  localparam logic [7:0] REG_OFF_B = 8'h33;
  localparam logic [7:0] REG_LINE_STATE = 8'h40;
  localparam logic [7:0] REG_HIGH_BATT = 8'h4a;
  localparam logic [7:0] REG_FREQ_COEF = 8'h50;
  localparam logic [7:0] REG_AMPL_COEF = 8'h51;
  localparam logic [7:0] REG_INIT_PHASE = 8'h52;
  localparam logic [7:0] REG_STATUS = 8'h53;
  localparam int ADDR_W = 10;
  // control register bit positions
  localparam int BIT_SHAPE = 0;
  localparam int BIT_OFFSET_EN = 1;
  localparam int BIT_ON_TMR_EN = 2;
  localparam int BIT_OFF_TMR_EN = 3;
  localparam int BIT_OSC_EN = 4;
  localparam logic [2:0] LINE_STATE_RINGING = 3'h4;
  localparam logic [2:0] LINE_STATE_ONHOOK_TX = 3'h2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // timing: clock, oscillator sample rate, cadence step
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_RATE_HZ = 1000;
  localparam int TONE_RATE_HZ = 8000;
  localparam int OSC_DIV = CLK_HZ / OSC_RATE_HZ;
  localparam int CAD_STEP_NS = 125_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAD_DIV = CAD_STEP_NS / CLK_PERIOD_NS;
endpackage

/* File: core/rwg_core.sv */
// ringing waveform generator with cadence timers and avalon-mm register slave
// Behaviour
// (R1) two-pole resonator, coefficients set frequency, amplitude
// (R2) oscillator updates at 1 kHz rate
// (R3) active and inactive cadence timers, 16-bit
// (R4) cadence timers move line into/out of ringing
// (R5) software keeps tone generator 2 off
// (R6) sine or trapezoid waveform selectable
// (R7) trapezoid ramp step programs crest factor
// (R8) optional programmable dc offset added
// (R9) line state code 100b means ringing
// (R10) active timer in two bytes 0x30, 0x31
// (R11) inactive timer in two bytes 0x32, 0x33
// (R12) cadence counts in 125 us steps
// (R13) shape bit 0 sine, 1 trapezoid
// (R14) offset added only while control bit 1 set
// (R15) active expiry stops, inactive expiry resumes ringing
// (R16) timers toggle oscillator enable when both enabled
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rwg_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [rwg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] ring_sample,
  output logic ring_sample_valid,
  output logic ringing_active,
  output logic [2:0] line_state_code,
  output logic [5:0] high_battery_setting
);
  import rwg_pkg::*;

  typedef enum logic [1:0] {CAD_IDLE, CAD_ON, CAD_OFF} rwg_cad_t;

  logic [7:0] ctrl_q;
  logic [15:0] on_period_count_q;
  logic [15:0] off_period_count_q;
  logic [2:0] line_q;
  logic [5:0] batt_q;
  logic [15:0] dc_offset_value_q;
  logic [15:0] freq_coef_q;
  logic [15:0] ampl_coef_q;
  logic [15:0] init_phase_q;
  logic waveform_shape_select;
  logic offset_add_enable;
  logic on_period_timer_enable;
  logic off_period_timer_enable;
  logic ring_oscillator_enable;
  logic auto_cadence;
  logic in_ring_state;
  logic osc_en_set;
  logic osc_en_clr;
  logic [7:0] word_index;
  logic bus_req;
  logic ack_q;
  logic wr_hit;
  logic [16:0] osc_div_q;
  logic osc_tick;
  logic [13:0] cad_div_q;
  logic cad_tick;
  rwg_cad_t cad_q;
  logic [15:0] cad_cnt_q;
  logic [15:0] y1_q;
  logic [15:0] y2_q;
  logic [15:0] trap_q;
  logic trap_dir_q;
  logic [15:0] trap_cnt_q;
  logic osc_started_q;
  logic [31:0] res_prod;
  logic [15:0] res_next;
  logic [16:0] trap_sum;
  logic [15:0] wave;
  logic [15:0] wave_off;

  assign waveform_shape_select = ctrl_q[BIT_SHAPE];
  assign offset_add_enable = ctrl_q[BIT_OFFSET_EN];
  assign on_period_timer_enable = ctrl_q[BIT_ON_TMR_EN];
  assign off_period_timer_enable = ctrl_q[BIT_OFF_TMR_EN];
  assign ring_oscillator_enable = ctrl_q[BIT_OSC_EN];
  assign auto_cadence = on_period_timer_enable && off_period_timer_enable;
  assign in_ring_state = (line_q == LINE_STATE_RINGING); // R9

  // bus: one wait cycle, answer on the second cycle of a request
  assign word_index = avs_address[ADDR_W-1:2];
  assign bus_req = avs_read || avs_write;
  assign wr_hit = avs_write && ack_q && avs_byteenable[0];
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && !ack_q);
    end
  end

  // read mux, unmapped words read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q) begin
      case (word_index)
        REG_CONTROL: avs_readdata <= {24'h0, ctrl_q};
        REG_ON_A: avs_readdata <= {24'h0, on_period_count_q[7:0]};
        REG_ON_B: avs_readdata <= {24'h0, on_period_count_q[15:8]};
        REG_OFF_A: avs_readdata <= {24'h0, off_period_count_q[7:0]};
        REG_OFF_B: avs_readdata <= {24'h0, off_period_count_q[15:8]};
        REG_LINE_STATE: avs_readdata <= {29'h0, line_q};
        REG_HIGH_BATT: avs_readdata <= {26'h0, batt_q};
        REG_DC_OFFSET_LO: avs_readdata <= {16'h0, dc_offset_value_q};
        REG_FREQ_COEF: avs_readdata <= {16'h0, freq_coef_q};
        REG_AMPL_COEF: avs_readdata <= {16'h0, ampl_coef_q};
        REG_INIT_PHASE: avs_readdata <= {16'h0, init_phase_q};
        REG_STATUS: avs_readdata <= {14'h0, cad_q, cad_cnt_q};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // byte registers for timers, line state and battery
  always_ff @(posedge clk) begin
    if (rst) begin
      on_period_count_q <= RESET_WORD;
      off_period_count_q <= RESET_WORD;
      line_q <= LINE_STATE_ONHOOK_TX;
      batt_q <= 6'h00;
    end else if (wr_hit) begin
      case (word_index)
        REG_ON_A: on_period_count_q[7:0] <= avs_writedata[7:0]; // R10
        REG_ON_B: on_period_count_q[15:8] <= avs_writedata[7:0]; // R10
        REG_OFF_A: off_period_count_q[7:0] <= avs_writedata[7:0]; // R11
        REG_OFF_B: off_period_count_q[15:8] <= avs_writedata[7:0]; // R11
        REG_LINE_STATE: line_q <= avs_writedata[2:0];
        REG_HIGH_BATT: batt_q <= avs_writedata[5:0];
        default: ;
      endcase
    end
  end

  // sixteen-bit coefficient and offset words
  always_ff @(posedge clk) begin
    if (rst) begin
      dc_offset_value_q <= RESET_WORD;
      freq_coef_q <= RESET_WORD;
      ampl_coef_q <= RESET_WORD;
      init_phase_q <= RESET_WORD;
    end else if (avs_write && ack_q) begin
      case (word_index)
        REG_DC_OFFSET_LO: begin
          if (avs_byteenable[0]) dc_offset_value_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) dc_offset_value_q[15:8] <= avs_writedata[15:8];
        end
        REG_FREQ_COEF: begin
          if (avs_byteenable[0]) freq_coef_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) freq_coef_q[15:8] <= avs_writedata[15:8];
        end
        REG_AMPL_COEF: begin
          if (avs_byteenable[0]) ampl_coef_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) ampl_coef_q[15:8] <= avs_writedata[15:8];
        end
        REG_INIT_PHASE: begin
          if (avs_byteenable[0]) init_phase_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) init_phase_q[15:8] <= avs_writedata[15:8];
        end
        default: ;
      endcase
    end
  end

  // control register; cadence hardware toggles the oscillator enable, hw wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= RESET_BYTE;
    end else begin
      if (wr_hit && word_index == REG_CONTROL) begin
        ctrl_q <= {3'h0, avs_writedata[4:0]};
      end
      if (osc_en_set) begin
        ctrl_q[BIT_OSC_EN] <= 1'b1; // R16
      end else if (osc_en_clr) begin
        ctrl_q[BIT_OSC_EN] <= 1'b0; // R16
      end
    end
  end

  // dividers: 1 kHz oscillator tick, 125 us cadence tick
  assign osc_tick = (osc_div_q == 17'(OSC_DIV - 1)); // R2
  assign cad_tick = (cad_div_q == 14'(CAD_DIV - 1)); // R12
  always_ff @(posedge clk) begin
    if (rst || osc_tick) begin
      osc_div_q <= 17'h0;
    end else begin
      osc_div_q <= osc_div_q + 17'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cad_tick) begin
      cad_div_q <= 14'h0;
    end else begin
      cad_div_q <= cad_div_q + 14'h1;
    end
  end

  // cadence: on period then off period, counter restarts at each expiry
  always_comb begin
    osc_en_set = 1'b0;
    osc_en_clr = 1'b0;
    if (cad_tick && in_ring_state && on_period_timer_enable) begin
      if (cad_q == CAD_ON && cad_cnt_q >= on_period_count_q) begin
        osc_en_clr = 1'b1; // R15
      end else if (cad_q == CAD_OFF && cad_cnt_q >= off_period_count_q && auto_cadence) begin
        osc_en_set = 1'b1; // R15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cad_q <= CAD_IDLE;
      cad_cnt_q <= 16'h0;
    end else if (!in_ring_state || !on_period_timer_enable) begin
      cad_q <= CAD_IDLE;
      cad_cnt_q <= 16'h0;
    end else if (cad_tick) begin
      case (cad_q)
        CAD_IDLE: begin
          cad_q <= ring_oscillator_enable ? CAD_ON : CAD_IDLE; // R3
          cad_cnt_q <= 16'h0;
        end
        CAD_ON: begin
          if (osc_en_clr) begin
            cad_q <= CAD_OFF;
            cad_cnt_q <= 16'h0;
          end else begin
            cad_cnt_q <= cad_cnt_q + 16'h1;
          end
        end
        CAD_OFF: begin
          if (osc_en_set) begin
            cad_q <= CAD_ON;
            cad_cnt_q <= 16'h0;
          end else if (cad_cnt_q != 16'hffff) begin
            cad_cnt_q <= cad_cnt_q + 16'h1;
          end
        end
        default: cad_q <= CAD_IDLE;
      endcase
    end
  end

  // line follows ringing only while the oscillator runs in ringing state
  always_ff @(posedge clk) begin
    if (rst) begin
      ringing_active <= 1'b0;
      line_state_code <= LINE_STATE_ONHOOK_TX;
      high_battery_setting <= 6'h00;
    end else begin
      ringing_active <= in_ring_state && ring_oscillator_enable; // R4
      line_state_code <= (in_ring_state && ring_oscillator_enable) ? LINE_STATE_RINGING
        : (in_ring_state ? LINE_STATE_ONHOOK_TX : line_q); // R4
      high_battery_setting <= batt_q;
    end
  end

  // resonator: y = 2*c*y1 - y2, coefficient in q15
  assign res_prod = $signed(freq_coef_q) * $signed(y1_q);
  assign res_next = 16'(res_prod[30:15] + res_prod[30:15] - y2_q); // R1
  assign trap_sum = trap_dir_q ? {1'b0, trap_q} + {1'b0, freq_coef_q}
    : {1'b0, trap_q} - {1'b0, freq_coef_q};
  assign wave = waveform_shape_select ? trap_q : y1_q; // R13
  assign wave_off = offset_add_enable ? 16'(wave + dc_offset_value_q) : wave; // R14

  always_ff @(posedge clk) begin
    if (rst) begin
      y1_q <= 16'h0;
      y2_q <= 16'h0;
      trap_q <= 16'h0;
      trap_dir_q <= 1'b1;
      trap_cnt_q <= 16'h0;
      osc_started_q <= 1'b0;
    end else if (!ring_oscillator_enable) begin
      osc_started_q <= 1'b0;
    end else if (osc_tick) begin
      if (!osc_started_q) begin
        // seed from amplitude and initial phase
        y1_q <= ampl_coef_q; // R1
        y2_q <= init_phase_q;
        trap_q <= 16'(-$signed(ampl_coef_q));
        trap_dir_q <= 1'b1;
        trap_cnt_q <= 16'h0;
        osc_started_q <= 1'b1;
      end else begin
        y2_q <= y1_q;
        y1_q <= res_next; // R1
        // trapezoid ramps by step, clamps at amplitude, flips each half period
        if (trap_dir_q && $signed(trap_sum[15:0]) > $signed(ampl_coef_q)) begin
          trap_q <= ampl_coef_q; // R7
        end else if (!trap_dir_q && $signed(trap_sum[15:0]) < -$signed(ampl_coef_q)) begin
          trap_q <= 16'(-$signed(ampl_coef_q)); // R7
        end else begin
          trap_q <= trap_sum[15:0]; // R6
        end
        if (trap_cnt_q + 16'h1 >= init_phase_q) begin
          trap_cnt_q <= 16'h0;
          trap_dir_q <= !trap_dir_q;
        end else begin
          trap_cnt_q <= trap_cnt_q + 16'h1;
        end
      end
    end
  end

  // sample output, zero while the oscillator is gated off
  always_ff @(posedge clk) begin
    if (rst) begin
      ring_sample <= 16'h0;
      ring_sample_valid <= 1'b0;
    end else begin
      ring_sample_valid <= osc_tick && ring_oscillator_enable && osc_started_q;
      if (!ring_oscillator_enable) begin
        ring_sample <= 16'h0; // R16
      end else if (osc_tick && osc_started_q) begin
        ring_sample <= wave_off; // R8
      end
    end
  end

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (rst)
    $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  AST_ONE_KHZ: assert property (@(posedge clk) disable iff (rst) // R2
    osc_tick |=> !osc_tick [*8])
    else $error("oscillator tick too close");
  AST_CAD_STEP: assert property (@(posedge clk) disable iff (rst) // R12
    cad_tick |=> !cad_tick [*8])
    else $error("cadence tick too close");
  AST_RING_CODE: assert property (@(posedge clk) disable iff (rst) // R9
    ringing_active |-> $past(line_q) == LINE_STATE_RINGING)
    else $error("ringing outside ringing state");
  AST_ON_EXPIRE: assert property (@(posedge clk) disable iff (rst) // R15
    osc_en_clr && !osc_en_set |=> !ring_oscillator_enable ##1 !ringing_active)
    else $error("active expiry did not stop ringing");
  AST_OFF_EXPIRE: assert property (@(posedge clk) disable iff (rst) // R16
    osc_en_set |=> ring_oscillator_enable)
    else $error("inactive expiry did not resume");
  AST_GATED: assert property (@(posedge clk) disable iff (rst) // R16
    !ring_oscillator_enable |=> ring_sample == 16'h0 && !ring_sample_valid)
    else $error("sample while oscillator off");
  AST_OFFSET: assert property (@(posedge clk) disable iff (rst) // R14
    osc_tick && ring_oscillator_enable && osc_started_q && !offset_add_enable
    |=> ring_sample == $past(wave))
    else $error("offset added while disabled");
  AST_TIMER_BYTE: assert property (@(posedge clk) disable iff (rst) // R10
    wr_hit && word_index == REG_ON_B |=> on_period_count_q[15:8] == $past(avs_writedata[7:0]))
    else $error("active timer high byte not stored");
endmodule

/* File: testbench/rwg_core_bench.sv */
// self-checking bench for the ringing generator registers and cadence
`timescale 1ns/1ps
module rwg_core_bench;
  import rwg_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] ring_sample;
  logic ring_sample_valid;
  logic ringing_active;
  logic [2:0] line_state_code;
  logic [5:0] high_battery_setting;
  int n_fail;
  int tests_run;
  int cyc;
  logic [31:0] rd;
  logic [7:0] regs [8];
  logic [31:0] wv [8];
  logic [31:0] ev [8];

  rwg_core dut (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ring_sample(ring_sample),
    .ring_sample_valid(ring_sample_valid),
    .ringing_active(ringing_active),
    .line_state_code(line_state_code),
    .high_battery_setting(high_battery_setting)
  );

  // clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one comparison, reported at once on mismatch
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one avalon-mm access, held until waitrequest is sampled low
  task automatic xfer(input bit wr, input logic [7:0] idx, input logic [31:0] data,
                      output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= data;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk("bus answer", {31'h0, avs_waitrequest}, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // read a register and compare
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, q);
    chk("readback", q, exp);
  endtask

  // wait for the ringing level under a bounded count
  task automatic wait_ring(input logic exp, input int maxc, output int n);
    n = 0;
    while (ringing_active !== exp && n < maxc) begin
      @(posedge clk);
      n++;
    end
    chk("ringing level", {31'h0, ringing_active}, {31'h0, exp});
  endtask

  // watchdog against a hang, about five cadence steps of work plus margin
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict;
  end

  // main sequence
  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    n_fail = 0;
    tests_run = 0;
    regs = '{REG_DC_OFFSET_LO, REG_CONTROL, REG_ON_A, REG_ON_B, REG_OFF_A, REG_OFF_B,
             REG_HIGH_BATT, REG_LINE_STATE};
    wv = '{32'ha5c3, 32'hff, 32'h34, 32'h12, 32'h78, 32'h56, 32'h2a, 32'h01};
    ev = '{32'ha5c3, 32'h1f, 32'h34, 32'h12, 32'h78, 32'h56, 32'h2a, 32'h01};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("reset line code", {29'h0, line_state_code}, {29'h0, LINE_STATE_ONHOOK_TX});
    chk("reset ringing", {31'h0, ringing_active}, 32'h0);
    // reset values, then write and read back the offset, control, timer, battery and line state registers
    for (int i = 0; i < 8; i++) begin
      rd_chk(regs[i], (i == 7) ? 32'h02 : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, regs[i], wv[i], rd);
    end
    for (int i = 0; i < 8; i++) begin
      rd_chk(regs[i], ev[i]);
    end
    chk("battery out", {26'h0, high_battery_setting}, 32'h2a);
    chk("line code idle", {29'h0, line_state_code}, 32'h1);
    // unmapped place ignores writes and reads zero
    xfer(1'b1, 8'h7f, 32'hdead_beef, rd);
    rd_chk(8'h7f, 32'h0);
    // ringing selected with the oscillator off stays paused
    xfer(1'b1, REG_CONTROL, 32'h0, rd);
    xfer(1'b1, REG_LINE_STATE, {29'h0, LINE_STATE_RINGING}, rd);
    repeat (3) @(posedge clk);
    chk("paused code", {29'h0, line_state_code}, {29'h0, LINE_STATE_ONHOOK_TX});
    chk("paused ringing", {31'h0, ringing_active}, 32'h0);
    chk("paused sample", {16'h0, ring_sample}, 32'h0);
    chk("paused valid", {31'h0, ring_sample_valid}, 32'h0);
    // direct software control of the oscillator enable
    xfer(1'b1, REG_CONTROL, 32'h1 << BIT_OSC_EN, rd);
    wait_ring(1'b1, 10, cyc);
    repeat (2) @(posedge clk);
    chk("ringing code", {29'h0, line_state_code}, {29'h0, LINE_STATE_RINGING});
    xfer(1'b1, REG_CONTROL, 32'h0, rd);
    wait_ring(1'b0, 10, cyc);
    // automatic cadence, timer counts of one give two steps on and two steps off
    xfer(1'b1, REG_ON_A, 32'h1, rd);
    xfer(1'b1, REG_ON_B, 32'h0, rd);
    xfer(1'b1, REG_OFF_A, 32'h1, rd);
    xfer(1'b1, REG_OFF_B, 32'h0, rd);
    xfer(1'b1, REG_CONTROL, (32'h1 << BIT_ON_TMR_EN) | (32'h1 << BIT_OFF_TMR_EN)
         | (32'h1 << BIT_OSC_EN), rd);
    wait_ring(1'b1, 10, cyc);
    // cadence enters its on period at the next 125 us step
    repeat (CAD_DIV + 2) @(posedge clk);
    xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk("on state", {30'h0, rd[17:16]}, 32'h1);
    wait_ring(1'b0, 3 * CAD_DIV, cyc);
    chk("on span", {31'h0, (cyc >= CAD_DIV / 2 && cyc <= 2 * CAD_DIV + 50)}, 32'h1);
    repeat (2) @(posedge clk);
    chk("off code", {29'h0, line_state_code}, {29'h0, LINE_STATE_ONHOOK_TX});
    xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk("off state", {30'h0, rd[17:16]}, 32'h2);
    wait_ring(1'b1, 3 * CAD_DIV, cyc);
    // leaving the ringing line state stops ringing
    xfer(1'b1, REG_LINE_STATE, 32'h1, rd);
    wait_ring(1'b0, 10, cyc);
    repeat (2) @(posedge clk);
    chk("left ringing", {29'h0, line_state_code}, 32'h1);
    give_verdict;
  end
endmodule
